// ### core/gpfgh_ports.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpfgh_defs.svh"

// Summary of operation
// - first port register mirrors its eight pins
// - input-only pin in input mode reads level
// - input-only pin in codes 00/01 reads zero
// - writes to input-only bits are ignored
// - first port defaults to input with pull-up
// - second port register is read-only pin mirror
// - second port defaults to input with pull-up
// - second port pull-ups follow its control register
// - mixed bit7 read/write resets 0, rest read-only
// - other-function mode stores bit, pin untouched
// - output mode drives stored bit onto pin
// - output mode read returns stored bit
// - input mode reads pin, writes still store
// - mixed bits 6..0 read low unless input
// - mixed port defaults to input with pull-up
// - only power-on reset clears mixed register
// - mixed pull-up on for 10, off 11
module gpfgh_ports
    import gpfgh_pkg::*;
#(
    parameter int DW = `GPFGH_DW
) (
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [`GPFGH_AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // function fields from the pin-function controller, two bits per pin
    input wire logic [2*DW-1:0] first_port_func,
    input wire logic [2*DW-1:0] second_port_func,
    input wire logic [2*DW-1:0] mixed_port_func,
    // pin levels
    input wire logic [DW-1:0] first_port_pin,
    input wire logic [DW-1:0] second_port_pin,
    input wire logic [DW-1:0] mixed_port_pin,
    // two-way writable pin of the mixed port
    output logic mixed_port_pin7_out,
    output logic mixed_port_pin7_oe,
    // pull-up enables towards the pads
    output logic [DW-1:0] second_port_pullup_en,
    output logic [DW-1:0] mixed_port_pullup_en,
    output logic [DW-1:0] first_port_pullup_en
);

    ////////////////////////////////////////////////////////////////////////
    // synchronised pin levels
    gpfgh_sync_if #(.W(3*DW)) sif ();
    assign sif.raw = {mixed_port_pin, second_port_pin, first_port_pin};

    gpfgh_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .sif(sif)
    );

    // synchronised levels per port
    logic [DW-1:0] first_lvl;
    logic [DW-1:0] second_lvl;
    logic [DW-1:0] mixed_lvl;
    assign first_lvl = sif.sync[DW-1:0];
    assign second_lvl = sif.sync[2*DW-1:DW];
    assign mixed_lvl = sif.sync[3*DW-1:2*DW];

    ////////////////////////////////////////////////////////////////////////
    // per-bit decode of function fields
    logic [DW-1:0] first_rd;    // read value of first port
    logic [DW-1:0] second_rd;   // read value of second port
    logic [DW-1:0] mixed_rd;    // read value of mixed port
    logic mixed_wbit;           // stored writable bit
    logic [DW-1:0] second_in;   // second port bit in input mode
    logic [DW-1:0] first_in;    // first port bit in input mode
    logic [DW-1:0] mixed_in;    // mixed port bit in input mode

    genvar gi;
    generate
        for (gi = 0; gi < DW; gi++) begin : g_bit
            // input modes are the codes with the high bit set
            assign first_in[gi] = first_port_func[2*gi+1];
            assign second_in[gi] = second_port_func[2*gi+1];
            assign mixed_in[gi] = mixed_port_func[2*gi+1];
            assign first_rd[gi] = first_in[gi] ? first_lvl[gi] : `GPFGH_LOW;
            assign second_rd[gi] = second_in[gi] ? second_lvl[gi] : `GPFGH_LOW;
            assign second_port_pullup_en[gi] =
                (second_port_func[2*gi+1 -: 2] == GPFGH_FN_IN_PU);
            // pull-up on for 10, off for 11
            assign mixed_port_pullup_en[gi] =
                (mixed_port_func[2*gi+1 -: 2] == GPFGH_FN_IN_PU);
            // first port pull-up follows the same coding
            assign first_port_pullup_en[gi] =
                (first_port_func[2*gi+1 -: 2] == GPFGH_FN_IN_PU);
            if (gi == `GPFGH_WBIT) begin : g_wbit
                assign mixed_rd[gi] = mixed_in[gi] ? mixed_lvl[gi] : mixed_wbit;
            end else begin : g_ro
                assign mixed_rd[gi] = mixed_in[gi] ? mixed_lvl[gi] : `GPFGH_LOW;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // address decode
    logic hit_first;   // first port selected
    logic hit_second;  // second port selected
    logic hit_mixed;   // mixed port selected
    assign hit_first = (reg_addr == `GPFGH_ADDR_FIRST);
    assign hit_second = (reg_addr == `GPFGH_ADDR_SECOND);
    assign hit_mixed = (reg_addr == `GPFGH_ADDR_MIXED);

    ////////////////////////////////////////////////////////////////////////
    // writable bit storage; only rst_n (power-on) clears it
    // power-on reset only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mixed_wbit <= `GPFGH_WBIT_RST;
        end else if (reg_wr && hit_mixed) begin
            mixed_wbit <= reg_wdata[`GPFGH_WBIT];
        end
    end
    // no other register bit is ever written

    ////////////////////////////////////////////////////////////////////////
    // pin drive of the writable bit
    // drive only in output mode
    assign mixed_port_pin7_oe =
        (mixed_port_func[2*`GPFGH_WBIT+1 -: 2] == GPFGH_FN_OUT);
    assign mixed_port_pin7_out = mixed_wbit;
    // defaults come from the controller's reset code

    ////////////////////////////////////////////////////////////////////////
    // read data, valid the cycle after the strobe, zero on unmapped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (hit_first) begin
                reg_rdata <= first_rd;
            end else if (hit_second) begin
                reg_rdata <= second_rd;
            end else if (hit_mixed) begin
                reg_rdata <= mixed_rd;
            end else begin
                reg_rdata <= '0;
            end
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule
`default_nettype wire

// ### include/gpfgh_defs.svh
`ifndef GPFGH_DEFS_SVH
`define GPFGH_DEFS_SVH

// register byte addresses
`define GPFGH_ADDR_FIRST 32'h0400012a
`define GPFGH_ADDR_SECOND 32'h0400012c
`define GPFGH_ADDR_MIXED 32'h0400012e
// address width of the register port
`define GPFGH_AW 32
// data width of each register
`define GPFGH_DW 8
// position of the writable bit in the mixed port
`define GPFGH_WBIT 7
// reset value of the writable bit
`define GPFGH_WBIT_RST 1'b0
// value read from a disabled input bit
`define GPFGH_LOW 1'b0
// default function field code (input, pull-up on)
`define GPFGH_FUNC_RST 2'h2
// synchroniser depth
`define GPFGH_SYNC_STAGES 2

`endif

// ### include/gpfgh_pkg.sv
package gpfgh_pkg;
    // per-pin function field codes
    typedef enum logic [1:0] {
        GPFGH_FN_OTHER = 2'h0,
        GPFGH_FN_OUT = 2'h1,
        GPFGH_FN_IN_PU = 2'h2,
        GPFGH_FN_IN_NOPU = 2'h3
    } gpfgh_func_t;
endpackage

// ### include/gpfgh_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// raw pin levels in, synchronised levels out
interface gpfgh_sync_if #(parameter int W = 24);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport owner (output raw, input sync);
    modport sync_end (input raw, output sync);
endinterface
`default_nettype wire

// ### core/gpfgh_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpfgh_defs.svh"
// two-flop synchroniser for all port pins
module gpfgh_sync (
    input wire logic mclk,
    input wire logic rst_n,
    gpfgh_sync_if.sync_end sif
);
    // first stage, read only by the second stage
    logic [$bits(sif.raw)-1:0] meta;
    // second stage, safe to use
    logic [$bits(sif.raw)-1:0] stable;

    ////////////////////////////////////////////////////////////////////////
    // two-flop capture
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            stable <= '0;
        end else begin
            meta <= sif.raw;
            stable <= meta;
        end
    end

    assign sif.sync = stable;
endmodule
`default_nettype wire

// ### sim/gpfgh_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// pads: pull-ups, released lines and two-way pin 7
module gpfgh_pins_model (
    input wire logic [23:0] drv,
    input wire logic flt,
    input wire logic [23:0] pu,
    input wire logic p7_out,
    input wire logic p7_oe,
    output logic [23:0] pins
);
    logic [23:0] pad; // level seen on each pad
    assign pad = flt ? (pu | ~drv) : drv;
    // device owns pin 7 while enabled
    assign pins = {p7_oe ? p7_out : pad[23], pad[22:0]};
endmodule
`default_nettype wire

// ### sim/gpfgh_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpfgh_defs.svh"
module gpfgh_checker #(
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [31:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DW-1:0] reg_rdata,
    input wire logic [2*DW-1:0] second_port_func,
    input wire logic [2*DW-1:0] mixed_port_func,
    input wire logic [DW-1:0] second_port_pin,
    input wire logic mixed_port_pin7_out,
    input wire logic mixed_port_pin7_oe,
    input wire logic [DW-1:0] mixed_port_pullup_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // read of the mixed port
    sequence s_mix_rd;
        reg_rd && reg_addr == `GPFGH_ADDR_MIXED;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_pin7_write: assert property (reg_wr && reg_addr == `GPFGH_ADDR_MIXED
        |=> mixed_port_pin7_out == $past(reg_wdata[7])) else $error("bit 7 not stored");
    a_pin7_hold: assert property (!(reg_wr && reg_addr == `GPFGH_ADDR_MIXED)
        |=> $stable(mixed_port_pin7_out)) else $error("bit 7 changed without write");
    a_out_enable: assert property (mixed_port_pin7_oe == (mixed_port_func[15:14] == 2'h1))
        else $error("pin 7 enable wrong");
    a_out_readback: assert property (s_mix_rd ##0 mixed_port_func[15:14] == 2'h1
        |=> reg_rdata[7] == $past(mixed_port_pin7_out)) else $error("bit 7 readback");
    a_ro_low: assert property (s_mix_rd ##0 !mixed_port_func[1] |=> !reg_rdata[0])
        else $error("bit 0 not low");
    a_second_level: assert property (reg_rd && reg_addr == `GPFGH_ADDR_SECOND
        && second_port_func == 16'haaaa && $past(rst_n, 3)
        && second_port_pin == $past(second_port_pin)
        && second_port_pin == $past(second_port_pin, 2)
        |=> reg_rdata == $past(second_port_pin)) else $error("second port level");
    a_mixed_pullup: assert property (mixed_port_pullup_en[7]
        == (mixed_port_func[15:14] == 2'h2)) else $error("pull-up wrong");
endmodule
`default_nettype wire

// ### sim/gpfgh_ports_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpfgh_defs.svh"
module gpfgh_ports_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [47:0] fn = {24{2'h2}}; // function fields, input with pull-up
    logic [23:0] drv = 24'h3ca55a; // external drive levels
    logic flt = 1'b0; // external drivers active
    logic [23:0] pins, pu;
    logic [7:0] rdata;
    logic p7_out, p7_oe;
    logic [1:0] c;
    int errors = 0;
    int checks = 0;
    always #4 mclk = ~mclk;
    gpfgh_ports i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .first_port_func(fn[15:0]),
        .second_port_func(fn[31:16]), .mixed_port_func(fn[47:32]),
        .first_port_pin(pins[7:0]), .second_port_pin(pins[15:8]),
        .mixed_port_pin(pins[23:16]), .mixed_port_pin7_out(p7_out),
        .mixed_port_pin7_oe(p7_oe), .second_port_pullup_en(pu[15:8]),
        .mixed_port_pullup_en(pu[23:16]), .first_port_pullup_en(pu[7:0]));
    gpfgh_pins_model i_pads (.drv(drv), .flt(flt), .pu(pu), .p7_out(p7_out),
        .p7_oe(p7_oe), .pins(pins));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        repeat (2000) @(posedge mclk);
        errors++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk({7'h00, p7_out}, 8'h00);
        chk(pu[7:0], 8'hff);
        chk(pu[15:8], 8'hff);
        rd_chk(`GPFGH_ADDR_FIRST, 8'h5a);
        rd_chk(`GPFGH_ADDR_MIXED, 8'h3c);
        rd_chk(32'h04000130, 8'h00);
        flt <= 1'b1;
        // released pads need two edges through the synchroniser
        repeat (2) @(posedge mclk);
        rd_chk(`GPFGH_ADDR_SECOND, 8'hff);
        fn <= {24{2'h3}};
        repeat (2) @(posedge mclk);
        rd_chk(`GPFGH_ADDR_MIXED, 8'hc3);
        flt <= 1'b0;
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            fn <= {24{c}};
            drv[23] <= c[0];
            wr_reg(`GPFGH_ADDR_FIRST, 8'hff);
            wr_reg(`GPFGH_ADDR_SECOND, 8'hff);
            wr_reg(`GPFGH_ADDR_MIXED, {~c[0], 7'h7f});
            #1 chk({5'h00, pins[23], p7_oe, p7_out}, {5'h00, &c, c == 2'h1, ~c[0]});
            rd_chk(`GPFGH_ADDR_FIRST, c[1] ? 8'h5a : 8'h00);
            rd_chk(`GPFGH_ADDR_SECOND, c[1] ? 8'ha5 : 8'h00);
            rd_chk(`GPFGH_ADDR_MIXED, c[1] ? {c[0], 7'h3c} : {~c[0], 7'h00});
        end
        $display("test function codes done");
        wr_reg(`GPFGH_ADDR_MIXED, 8'h80);
        #1 chk({7'h00, p7_out}, 8'h01);
        rst_n <= 1'b0;
        @(posedge mclk);
        #1 chk({7'h00, p7_out}, 8'h00);
        rst_n <= 1'b1;
        $display("test reset done");
        close_out();
    end
endmodule
bind gpfgh_ports gpfgh_checker #(.DW(DW)) u_chk (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .second_port_func(second_port_func),
    .mixed_port_func(mixed_port_func), .second_port_pin(second_port_pin),
    .mixed_port_pin7_out(mixed_port_pin7_out), .mixed_port_pin7_oe(mixed_port_pin7_oe),
    .mixed_port_pullup_en(mixed_port_pullup_en));
`default_nettype wire
